/* hw/cpm_core.sv */
// Processor register model reached over an AHB-Lite slave port.
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_core
   import cpm_pkg::*;
(
   // Clock and reset.
   input  logic        clk,
   input  logic        reset_n,
   // AHB-Lite slave.
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic [31:0] hrdata,
   output logic        hreadyout,
   output logic        hresp,
   // Processor state for the rest of the chip.
   output cpm_status_t status
);

////////////////////////////////////////////////////////////////////////////////

   cpm_state_t  s_r;
   cpm_state_t  s_nxt;
   logic [3:0]  acr_hit;
   logic        sup;
   logic        viol_now;
   logic        wr_now;
   logic        rd_now;
   cpm_ea_ctl_t c;
   logic [31:0] base;
   logic [31:0] ix;
   logic [31:0] disp;
   logic [31:0] od;
   logic [31:0] step;
   logic [31:0] ea;
   logic [31:0] src;
   logic [31:0] dst;
   logic [31:0] rd;
   logic [31:0] wv;
   logic [31:0] old;
   logic [3:0]  ax;
   logic [3:0]  ay;
   logic [7:0]  aoff;

////////////////////////////////////////////////////////////////////////////////

   // Active stack: user, interrupt or master.
   function automatic logic [1:0] sp_sel(input logic [15:0] sr);
      if (!sr[`CPM_SR_S])
         sp_sel = 2'd0;
      else if (sr[`CPM_SR_M])
         sp_sel = 2'd2;
      else
         sp_sel = 2'd1;
   endfunction

   // Index 15 is the stack pointer view of register seven.
   function automatic logic [31:0] rreg(input cpm_state_t st,
                                        input logic [3:0] i);
      if (i == 4'hF)
         rreg = st.sp[sp_sel(st.sr)];
      else
         rreg = st.gpr[i];
   endfunction

   function automatic cpm_state_t wreg(input cpm_state_t st,
                                       input logic [3:0] i,
                                       input logic [31:0] v);
      wreg = st;
      if (i == 4'hF)
         wreg.sp[sp_sel(st.sr)] = v;
      else
         wreg.gpr[i] = v;
   endfunction

   // Size code 0 means no displacement at all.
   function automatic logic [31:0] sext(input logic [31:0] v,
                                        input logic [1:0] sz);
      unique case (sz)
         2'd0: sext = 32'h0000_0000;
         2'd1: sext = {{24{v[7]}}, v[7:0]};
         2'd2: sext = {{16{v[15]}}, v[15:0]};
         2'd3: sext = v;
      endcase
   endfunction

   function automatic logic priv_reg(input logic [7:0] a);
      priv_reg = (a >= `CPM_A_USP && a <= `CPM_A_MSP) ||
                 (a == `CPM_A_SR) ||
                 (a >= `CPM_A_VBR && a <= `CPM_A_ACR3);
   endfunction

////////////////////////////////////////////////////////////////////////////////

   // One comparator per access control block; the mask bits are don't-care.
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_acr
         assign acr_hit[g] = s_r.acr[g][`CPM_ACR_E] &&
            (((s_r.probe[31:24] ^ s_r.acr[g][31:24]) &
              ~s_r.acr[g][23:16]) == 8'h00);
      end
   endgenerate

////////////////////////////////////////////////////////////////////////////////

   // Read mux, sampled in the wait cycle of a read.
   always_comb
   begin
      rd = 32'h0000_0000;
      aoff = s_r.dad - `CPM_A_ACR0;
      if (s_r.dad < `CPM_A_GPR_END)
         rd = rreg(s_r, s_r.dad[5:2]);
      else
      begin
         unique case (s_r.dad)
            8'h40, 8'h44, 8'h48: rd = s_r.sp[s_r.dad[3:2]];
            `CPM_A_PC:     rd = s_r.pc;
            `CPM_A_SR:     rd = {16'h0000, s_r.sr};
            `CPM_A_CCR:    rd = {24'h00_0000, s_r.sr[7:0]};
            `CPM_A_VBR:    rd = s_r.vector_table_base;
            `CPM_A_SFC:    rd = {29'h0, s_r.source_space_code};
            `CPM_A_DFC:    rd = {29'h0, s_r.dfc};
            `CPM_A_CACHE_CONTROL_WORD:   rd = s_r.cache_control_word;
            8'h68, 8'h6C, 8'h70, 8'h74: rd = s_r.acr[aoff[3:2]];
            `CPM_A_EACTL:  rd = {10'h000, s_r.ea_ctl};
            `CPM_A_EADISP: rd = s_r.ea_disp;
            `CPM_A_EARES:  rd = s_r.ea_res;
            `CPM_A_FCSEL:  rd = {26'h0, s_r.fc, s_r.fc_sel};
            `CPM_A_EXST:   rd = {23'h0, s_r.viol, s_r.last_vec};
            `CPM_A_BLKS:   rd = s_r.blk_src;
            `CPM_A_BLKD:   rd = s_r.blk_dst;
            `CPM_A_QSEL:   rd = {26'h0, s_r.qsel};
            `CPM_A_QHI:    rd = s_r.gpr[{1'b0, s_r.qsel[2:0]}];
            `CPM_A_QLO:    rd = s_r.gpr[{1'b0, s_r.qsel[5:3]}];
            `CPM_A_EAIND:  rd = s_r.ea_ind;
            `CPM_A_EAOD:   rd = s_r.ea_od;
            `CPM_A_PROBE:  rd = {28'h0, acr_hit};
            default:       rd = 32'h0000_0000;
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      s_nxt = s_r;
      sup = s_r.sr[`CPM_SR_S];
      c = cpm_ea_ctl_t'(hwdata[21:0]);
      base = 32'h0000_0000;
      ix = 32'h0000_0000;
      disp = 32'h0000_0000;
      od = 32'h0000_0000;
      step = 32'h0000_0000;
      ea = 32'h0000_0000;
      src = 32'h0000_0000;
      dst = 32'h0000_0000;
      ax = 4'h0;
      ay = 4'h0;
      old = s_r.gpr[s_r.dad[5:2]];
      wr_now = s_r.dph && s_r.dwr && !s_r.dhi;
      rd_now = s_r.dph && s_r.rwait;
      // A user access to a privileged register does nothing but trap.
      viol_now = (wr_now || (rd_now && !s_r.dhi)) && !sup &&
                 priv_reg(s_r.dad);

      // Narrow writes: data registers keep their upper bits, address
      // registers take a sign-extended word.
      if (s_r.dad[5])
         wv = (s_r.dsz == 3'd1) ? sext(hwdata, 2'd2) : hwdata;
      else if (s_r.dsz == 3'd0)
         wv = {old[31:8], hwdata[7:0]};
      else if (s_r.dsz == 3'd1)
         wv = {old[31:16], hwdata[15:0]};
      else
         wv = hwdata;

      if (viol_now)
      begin
         s_nxt.viol = 1'b1;
         s_nxt.last_vec = `CPM_VEC_PRIV;
         s_nxt.pc = s_r.vector_table_base + {22'h0, `CPM_VEC_PRIV, 2'b00};
         s_nxt.sr[`CPM_SR_S] = 1'b1;
      end
      else if (wr_now)
      begin
         if (s_r.dad < `CPM_A_GPR_END)
            s_nxt = wreg(s_r, s_r.dad[5:2], wv);
         else
         begin
            unique case (s_r.dad)
               8'h40, 8'h44, 8'h48: s_nxt.sp[s_r.dad[3:2]] = hwdata;
               `CPM_A_PC:     s_nxt.pc = hwdata;
               `CPM_A_SR:     s_nxt.sr = hwdata[15:0];
               `CPM_A_CCR:    s_nxt.sr[7:0] = hwdata[7:0];
               `CPM_A_VBR:    s_nxt.vector_table_base = hwdata;
               `CPM_A_SFC:    s_nxt.source_space_code = hwdata[2:0];
               `CPM_A_DFC:    s_nxt.dfc = hwdata[2:0];
               `CPM_A_CACHE_CONTROL_WORD:   s_nxt.cache_control_word = hwdata;
               8'h68, 8'h6C, 8'h70, 8'h74:
                  s_nxt.acr[aoff_w(s_r.dad)] = hwdata;
               `CPM_A_EADISP: s_nxt.ea_disp = hwdata;
               `CPM_A_EAIND:  s_nxt.ea_ind = hwdata;
               `CPM_A_EAOD:   s_nxt.ea_od = hwdata;
               `CPM_A_FCSEL:  s_nxt.fc_sel = hwdata[2:0];
               `CPM_A_QSEL:   s_nxt.qsel = hwdata[5:0];
               `CPM_A_QHI:    s_nxt.gpr[{1'b0, s_r.qsel[2:0]}] = hwdata;
               `CPM_A_QLO:    s_nxt.gpr[{1'b0, s_r.qsel[5:3]}] = hwdata;
               `CPM_A_PROBE:  s_nxt.probe = hwdata;
               `CPM_A_PCADV:  s_nxt.pc = s_r.pc + hwdata;
               `CPM_A_EXST:
                  if (hwdata[`CPM_EXST_VIOL])
                     s_nxt.viol = 1'b0;
               `CPM_A_EXC:
               begin
                  s_nxt.last_vec = hwdata[7:0];
                  s_nxt.pc = s_r.vector_table_base + {22'h0, hwdata[7:0], 2'b00};
                  s_nxt.sr[`CPM_SR_S] = 1'b1;
               end
               `CPM_A_BLK:
               begin
                  // Both pointers step by a whole line, as in (Ax)+,(Ay)+.
                  ax = {1'b1, hwdata[2:0]};
                  ay = {1'b1, hwdata[6:4]};
                  src = rreg(s_r, ax);
                  dst = rreg(s_r, ay);
                  s_nxt.blk_src = {src[31:4], 4'h0};
                  s_nxt.blk_dst = {dst[31:4], 4'h0};
                  s_nxt = wreg(s_nxt, ax, src + `CPM_BLK_STEP);
                  s_nxt = wreg(s_nxt, ay, dst + `CPM_BLK_STEP);
               end
               `CPM_A_EACTL:
               begin
                  s_nxt.ea_ctl = c;
                  base = c.base_pc ? s_r.pc : rreg(s_r, c.base_reg);
                  ix = rreg(s_r, c.idx_reg);
                  if (!c.idx_long)
                     ix = sext(ix, 2'd2);
                  ix = c.idx_en ? (ix << c.scale) : 32'h0000_0000;
                  disp = sext(s_r.ea_disp, c.disp_sz);
                  od = c.od_long ? s_r.ea_od : sext(s_r.ea_od, 2'd2);
                  step = 32'h0000_0001 << c.op_log2;
                  unique case (c.mode)
                     EA_DISP:    ea = base + disp + ix;
                     EA_POSTINC:
                     begin
                        ea = base;
                        if (!c.base_pc)
                           s_nxt = wreg(s_nxt, c.base_reg, base + step);
                     end
                     EA_PREDEC:
                     begin
                        ea = base - step;
                        if (!c.base_pc)
                           s_nxt = wreg(s_nxt, c.base_reg, ea);
                     end
                     EA_IMM:     ea = disp;
                     EA_MEMPRE:  ea = s_r.ea_ind + od;
                     EA_MEMPOST: ea = s_r.ea_ind + ix + od;
                     default:    ea = 32'h0000_0000;
                  endcase
                  s_nxt.ea_res = ea;
               end
               default: s_nxt.probe = s_r.probe;
            endcase
         end
      end

      // Reads take one wait cycle so that hrdata comes from a flop.
      if (rd_now)
      begin
         s_nxt.rwait = 1'b0;
         s_nxt.rdata = (viol_now || s_r.dhi) ? 32'h0000_0000 : rd;
      end

      if (hsel && hready && htrans[1])
      begin
         s_nxt.dph = 1'b1;
         s_nxt.dwr = hwrite;
         s_nxt.rwait = !hwrite;
         s_nxt.dad = {haddr[7:2], 2'b00};
         s_nxt.dhi = |haddr[31:8];
         s_nxt.dsz = hsize;
      end
      else if (hready)
         s_nxt.dph = 1'b0;

      // Space code of the next access, alternate or derived from mode.
      if (s_nxt.fc_sel[1])
         s_nxt.fc = s_nxt.fc_sel[2] ? s_nxt.dfc : s_nxt.source_space_code;
      else
         s_nxt.fc = {s_nxt.sr[`CPM_SR_S], s_nxt.fc_sel[0],
                     !s_nxt.fc_sel[0]};
   end

   function automatic logic [1:0] aoff_w(input logic [7:0] a);
      logic [7:0] d;
      d = a - `CPM_A_ACR0;
      aoff_w = d[3:2];
   endfunction

////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_r <= '0;
         s_r.sr <= `CPM_SR_RST;
         // Supervisor data space, so the code is right from the first edge.
         s_r.fc <= 3'h5;
      end
      else
         s_r <= s_nxt;
   end

   assign hreadyout = !(s_r.dph && s_r.rwait);
   assign hrdata = s_r.rdata;
   assign hresp = 1'b0;
   assign status.supervisor = s_r.sr[`CPM_SR_S];
   assign status.icache_en = s_r.cache_control_word[`CPM_CACHE_CONTROL_WORD_IE];
   assign status.dcache_en = s_r.cache_control_word[`CPM_CACHE_CONTROL_WORD_DE];
   assign status.fc_code = s_r.fc;
   assign status.priv_fault = s_r.viol;

endmodule

/* inc/cpm_defines.svh */
// Register offsets, field positions and reset values of the register core.
// How it works
// - Registers split into user and supervisor levels; user code reaches user level only.
// - User model holds sixteen 32-bit general registers and two control registers.
// - Access control registers are read and written only at supervisor level.
// - Register seven is user stack in user mode, interrupt or master stack otherwise.
// - Status low byte holds condition flags, reachable by users as its own register.
// - Status high byte holds control information, reachable at supervisor level only.
// - The program counter either advances or takes a new value as needed.
// - An exception vector number indexes a table based at the vector base register.
// - Source and destination space code registers each hold a three-bit code.
// - Space codes are made from program/data and user/supervisor, or taken from an alternate space code register.
// - The cache control word enables the instruction and data caches.
// - Four access control registers, two instruction and two data, mark address blocks.
// - A 64-bit integer is held across any pair of data registers.
// - The 128-bit block operand lives in memory on a sixteen-byte boundary.
// - An index is word or long and is scaled by one, two, four or eight.
// - Short 8 or 16 bit displacements are sign-extended; a missing one is zero.
// - Memory-indirect modes add a 16 or 32 bit outer displacement after fetch.
// - Indirect modes offer postincrement, predecrement, displacement and index forms.
// - Immediate operands are 8, 16 or 32 bits wide.
// - A user block copy moves sixteen bytes at a time.
// - Address registers take word and long writes; any register may be an index.
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
`define CPM_A_GPR_END 8'h40
`define CPM_A_USP     8'h40
`define CPM_A_MSP     8'h48
`define CPM_A_PC      8'h4C
`define CPM_A_SR      8'h50
`define CPM_A_CCR     8'h54
`define CPM_A_VBR     8'h58
`define CPM_A_SFC     8'h5C
`define CPM_A_DFC     8'h60
`define CPM_A_CACHE_CONTROL_WORD    8'h64
`define CPM_A_ACR0    8'h68
`define CPM_A_ACR3    8'h74
`define CPM_A_EACTL   8'h78
`define CPM_A_EADISP  8'h7C
`define CPM_A_EARES   8'h80
`define CPM_A_FCSEL   8'h84
`define CPM_A_EXC     8'h88
`define CPM_A_EXST    8'h8C
`define CPM_A_PCADV   8'h90
`define CPM_A_BLK     8'h94
`define CPM_A_BLKS    8'h98
`define CPM_A_BLKD    8'h9C
`define CPM_A_QSEL    8'hA0
`define CPM_A_QHI     8'hA4
`define CPM_A_QLO     8'hA8
`define CPM_A_EAIND   8'hAC
`define CPM_A_EAOD    8'hB0
`define CPM_A_PROBE   8'hB4
`define CPM_SR_RST    16'h2700
`define CPM_SR_S      13
`define CPM_SR_M      12
`define CPM_VEC_PRIV  8'h08
`define CPM_EXST_VIOL 8
`define CPM_CACHE_CONTROL_WORD_DE   31
`define CPM_CACHE_CONTROL_WORD_IE   15
`define CPM_ACR_E     15
`define CPM_BLK_STEP  32'h0000_0010
`endif

/* inc/cpm_pkg.sv */
// Types shared by the register core and its bench.
package cpm_pkg;

   typedef enum logic [2:0] {
      EA_DISP,
      EA_POSTINC,
      EA_PREDEC,
      EA_IMM,
      EA_MEMPRE,
      EA_MEMPOST
   } cpm_ea_mode_t;

   typedef struct packed {
      logic [2:0]   op_log2;
      logic         od_long;
      cpm_ea_mode_t mode;
      logic [1:0]   disp_sz;
      logic [1:0]   scale;
      logic         idx_long;
      logic         idx_en;
      logic [3:0]   idx_reg;
      logic         base_pc;
      logic [3:0]   base_reg;
   } cpm_ea_ctl_t;

   typedef struct packed {
      logic       supervisor;
      logic       icache_en;
      logic       dcache_en;
      logic [2:0] fc_code;
      logic       priv_fault;
   } cpm_status_t;

   typedef struct packed {
      logic [14:0][31:0] gpr;
      logic [2:0][31:0]  sp;
      logic [31:0]       pc;
      logic [15:0]       sr;
      logic [31:0]       vector_table_base;
      logic [2:0]        source_space_code;
      logic [2:0]        dfc;
      logic [31:0]       cache_control_word;
      logic [3:0][31:0]  acr;
      cpm_ea_ctl_t       ea_ctl;
      logic [31:0]       ea_disp;
      logic [31:0]       ea_ind;
      logic [31:0]       ea_od;
      logic [31:0]       ea_res;
      logic [2:0]        fc_sel;
      logic [2:0]        fc;
      logic [31:0]       blk_src;
      logic [31:0]       blk_dst;
      logic [31:0]       probe;
      logic [5:0]        qsel;
      logic              viol;
      logic [7:0]        last_vec;
      logic              dph;
      logic              dwr;
      logic              rwait;
      logic              dhi;
      logic [7:0]        dad;
      logic [2:0]        dsz;
      logic [31:0]       rdata;
   } cpm_state_t;

endpackage

/* verif/cpm_core_assertions.sv */
// Checker bound to the bus and status ports of the register core.
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_core_chk
   import cpm_pkg::*;
(
   // Clock and reset.
   input logic        clk,
   input logic        reset_n,
   // Bus side.
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] hwdata,
   input logic        hready,
   input logic [31:0] hrdata,
   input logic        hreadyout,
   input logic        hresp,
   // Processor state.
   input cpm_status_t status
);
   logic taken;
   logic cache_control_word_wr;
   logic sr_wr;
   logic exst_wr;
   assign taken   = hsel && hready && htrans[1];
   assign cache_control_word_wr = taken && hwrite && haddr == {24'h0, `CPM_A_CACHE_CONTROL_WORD};
   assign sr_wr   = taken && hwrite && haddr == {24'h0, `CPM_A_SR};
   assign exst_wr = taken && hwrite && haddr == {24'h0, `CPM_A_EXST};
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence rd_take;
      taken && !hwrite;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("response not okay");
   read_wait_a: assert property (rd_take |=> one_wait)
      else $error("read wait wrong");
   write_go_a: assert property (taken && hwrite |=> hreadyout)
      else $error("write waited");
   // The edge that releases reset must show the reset mode.
   reset_mode_a: assert property ($rose(reset_n) |->
      status.supervisor && status.fc_code == 3'h5)
      else $error("reset mode wrong");
   cache_cause_a: assert property ($changed(status.icache_en) ||
      $changed(status.dcache_en) |-> $past(cache_control_word_wr, 2))
      else $error("cache enable moved alone");
   cache_value_a: assert property (cache_control_word_wr && status.supervisor ##1 1'b1 |=>
      status.icache_en == $past(hwdata[`CPM_CACHE_CONTROL_WORD_IE]) &&
      status.dcache_en == $past(hwdata[`CPM_CACHE_CONTROL_WORD_DE]))
      else $error("cache enable value wrong");
   sup_leave_a: assert property ($fell(status.supervisor) |->
      $past(sr_wr, 2))
      else $error("left supervisor alone");
   fault_trap_a: assert property ($rose(status.priv_fault) |->
      $rose(status.supervisor))
      else $error("fault without trap");
   fault_clear_a: assert property ($fell(status.priv_fault) |->
      $past(exst_wr, 2))
      else $error("fault cleared alone");
   rdata_hold_a: assert property ($changed(hrdata) |->
      !hreadyout || $past(!hreadyout))
      else $error("read data moved");
endmodule
////////////////////////////////////////////////////////////////////////////
bind cpm_core cpm_core_chk u_chk (
   .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .status(status)
);

/* verif/cpu_programming_model_bench.sv */
// Self-checking bench for the processor register core.
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpu_programming_model_bench
   import cpm_pkg::*;
   ;
   localparam int LIMIT = 5000;
   logic        clk;
   logic        reset_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        hro_n;
   logic [31:0] hrd_n;
   cpm_status_t status;
   cpm_status_t st_n;
   int          miscompares;
   int          tests_run;
   int          cycles;
   cpm_core u_dut (
      .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .status(status)
   );
   always #12.5 clk = ~clk;
   // Copies taken at the falling edge let tasks read outputs without races.
   always @(negedge clk)
   begin
      hro_n <= hreadyout;
      hrd_n <= hrdata;
      st_n  <= status;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         miscompares++;
         complete_run();
      end
   end
////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (hro_n !== 1'b1 && n < 8);
      if (hro_n !== 1'b1)
         chk("hreadyout", 32'h1, 32'h0);
   endtask
   task automatic bus_op(input logic wr, input logic [31:0] a,
                         input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrd_n;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_op(1'b1, {24'h0, a}, d, q);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      logic [31:0] q;
      bus_op(1'b0, {24'h0, a}, 32'h0, q);
      chk(what, exp, q);
   endtask
   task automatic fc_chk(input logic [2:0] sel, input logic [2:0] exp);
      logic [31:0] q;
      wr(`CPM_A_FCSEL, {29'h0, sel});
      bus_op(1'b0, {24'h0, `CPM_A_FCSEL}, 32'h0, q);
      chk("space code", {29'h0, exp}, {29'h0, q[5:3]});
   endtask
////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] q;
      @(posedge clk);
      chk("supervisor", 32'h1, 32'(st_n.supervisor));
      chk("code", 32'h5, {29'h0, st_n.fc_code});
      rd_chk("status word", `CPM_A_SR, {16'h0, `CPM_SR_RST});
      rd_chk("cache word", `CPM_A_CACHE_CONTROL_WORD, 32'h0);
      bus_op(1'b0, 32'h0000_0100, 32'h0, q);
      chk("unmapped", 32'h0, q);
      $display("reset test done");
   endtask
   task automatic t_regs();
      for (int i = 0; i < 15; i++)
         wr(8'(i * 4), 32'hA5C3_0000 + 32'(i));
      for (int i = 0; i < 15; i++)
         rd_chk("general", 8'(i * 4), 32'hA5C3_0000 + 32'(i));
      wr(8'h3C, 32'hCAFE_0010);
      rd_chk("interrupt stack", 8'h44, 32'hCAFE_0010);
      wr(`CPM_A_SR, 32'h0000_3700);
      wr(8'h3C, 32'h0000_BEE0);
      rd_chk("master stack", `CPM_A_MSP, 32'h0000_BEE0);
      rd_chk("interrupt kept", 8'h44, 32'hCAFE_0010);
      wr(`CPM_A_SR, {16'h0, `CPM_SR_RST});
      $display("register test done");
   endtask
   task automatic t_cache();
      logic [31:0] v [3] = '{32'h8000_8000, 32'h0000_8000, 32'h8000_0000};
      for (int i = 0; i < 3; i++)
      begin
         wr(`CPM_A_CACHE_CONTROL_WORD, v[i]);
         @(posedge clk);
         chk("icache", 32'(v[i][`CPM_CACHE_CONTROL_WORD_IE]), 32'(st_n.icache_en));
         chk("dcache", 32'(v[i][`CPM_CACHE_CONTROL_WORD_DE]), 32'(st_n.dcache_en));
      end
      $display("cache test done");
   endtask
   task automatic t_ctrl();
      wr(`CPM_A_VBR, 32'h0000_1000);
      wr(`CPM_A_EXC, 32'h0000_0005);
      rd_chk("vector pc", `CPM_A_PC, 32'h0000_1014);
      wr(`CPM_A_PCADV, 32'h0000_0006);
      rd_chk("advanced pc", `CPM_A_PC, 32'h0000_101A);
      wr(`CPM_A_SFC, 32'hFFFF_FFFF);
      wr(`CPM_A_DFC, 32'h0000_000A);
      rd_chk("source code", `CPM_A_SFC, 32'h7);
      rd_chk("dest code", `CPM_A_DFC, 32'h2);
      fc_chk(3'h0, 3'h5);
      fc_chk(3'h1, 3'h6);
      fc_chk(3'h2, 3'h7);
      fc_chk(3'h6, 3'h2);
      $display("control test done");
   endtask
   task automatic t_user();
      logic [31:0] q;
      wr(`CPM_A_ACR0, 32'h1234_8000);
      wr(`CPM_A_ACR3, 32'h1200_8000);
      wr(`CPM_A_PROBE, 32'h1200_0040);
      bus_op(1'b0, {24'h0, `CPM_A_PROBE}, 32'h0, q);
      chk("hits", 32'h9, {28'h0, q[3:0]});
      wr(`CPM_A_SR, 32'h0000_0000);
      @(posedge clk);
      chk("user mode", 32'h0, 32'(st_n.supervisor));
      wr(8'h3C, 32'h0000_0BB0);
      wr(`CPM_A_CCR, 32'h0000_0015);
      rd_chk("condition byte", `CPM_A_CCR, 32'h0000_0015);
      fc_chk(3'h0, 3'h1);
      fc_chk(3'h1, 3'h2);
      wr(`CPM_A_ACR0, 32'hFFFF_FFFF);
      @(posedge clk);
      chk("fault", 32'h1, 32'(st_n.priv_fault));
      chk("trap mode", 32'h1, 32'(st_n.supervisor));
      rd_chk("acr kept", `CPM_A_ACR0, 32'h1234_8000);
      rd_chk("trap pc", `CPM_A_PC, 32'h0000_1020);
      rd_chk("user stack", `CPM_A_USP, 32'h0000_0BB0);
      rd_chk("trap status", `CPM_A_EXST, 32'h0000_0108);
      wr(`CPM_A_EXST, 32'h0000_0100);
      rd_chk("cleared", `CPM_A_EXST, 32'h0000_0008);
      $display("privilege test done");
   endtask
   task automatic t_ops();
      logic [31:0] e [3][5] = '{
         '{32'h80, 32'h0, 32'h0, 32'h3E28, 32'hF98},
         '{32'h8000, 32'h0, 32'h0, 32'h1C000, 32'hFFFF_8000},
         '{32'h0, 32'h5000, 32'h100, 32'h60000, 32'h5100}};
      wr(8'h08, 32'hDEAD_0002);
      wr(8'h14, 32'h0BEE_0005);
      wr(`CPM_A_QSEL, 32'h0000_002A);
      rd_chk("pair high", `CPM_A_QHI, 32'hDEAD_0002);
      rd_chk("pair low", `CPM_A_QLO, 32'h0BEE_0005);
      wr(8'h24, 32'h0000_2013);
      wr(8'h28, 32'h0000_3007);
      wr(`CPM_A_BLK, 32'h0000_0021);
      rd_chk("block src", `CPM_A_BLKS, 32'h0000_2010);
      rd_chk("block dst", `CPM_A_BLKD, 32'h0000_3000);
      rd_chk("src step", 8'h24, 32'h0000_2013 + `CPM_BLK_STEP);
      rd_chk("dst step", 8'h28, 32'h0000_3007 + `CPM_BLK_STEP);
      wr(8'h04, 32'h0000_0003);
      wr(8'h20, 32'h0000_1000);
      for (int i = 0; i < 3; i++)
      begin
         wr(`CPM_A_EADISP, e[i][0]);
         wr(`CPM_A_EAIND, e[i][1]);
         wr(`CPM_A_EAOD, e[i][2]);
         wr(`CPM_A_EACTL, e[i][3]);
         rd_chk("address", `CPM_A_EARES, e[i][4]);
      end
      $display("operand test done");
   endtask
////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_regs();
      t_cache();
      t_ctrl();
      t_user();
      t_ops();
      complete_run();
   end
endmodule
